// >>> inc/lone_pkg.sv
// shared constants for the logical-or and no-operation execute block
package lone_pkg;
  localparam logic [31:0] LONE_NOP_WORD       = 32'hd503201f;
  localparam logic [63:0] LONE_PC_STEP        = 64'h0000000000000004;
  localparam logic [63:0] LONE_PC_RESET       = 64'h0000000000000000;
  // field positions of the instruction word
  localparam int          LONE_SF_BIT         = 31;
  localparam int          LONE_OPC_HI         = 30;
  localparam int          LONE_OPC_LO         = 24;
  localparam int          LONE_IMMOP_LO       = 23;
  localparam int          LONE_SHTYPE_HI      = 23;
  localparam int          LONE_SHTYPE_LO      = 22;
  localparam int          LONE_N_BIT          = 22;
  localparam int          LONE_INV_BIT        = 21;
  localparam int          LONE_RM_HI          = 20;
  localparam int          LONE_RM_LO          = 16;
  localparam int          LONE_IMMR_HI        = 21;
  localparam int          LONE_IMMR_LO        = 16;
  localparam int          LONE_AMT_HI         = 15;
  localparam int          LONE_AMT_LO         = 10;
  localparam int          LONE_RN_HI          = 9;
  localparam int          LONE_RN_LO          = 5;
  localparam int          LONE_RD_HI          = 4;
  localparam int          LONE_RD_LO          = 0;
  localparam logic [6:0]  LONE_OPC_SHREG      = 7'h2a;
  localparam logic [7:0]  LONE_OPC_IMM        = 8'h64;
  localparam logic [4:0]  LONE_ZERO_REG       = 5'h1f;
  localparam logic [5:0]  LONE_AMT_ZERO       = 6'h00;
  localparam logic [6:0]  LONE_WIDTH_BASE     = 7'h20;
  // register map, byte addresses
  localparam logic [7:0]  LONE_ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  LONE_ADDR_RETIRED   = 8'h04;
  localparam logic [7:0]  LONE_ADDR_UNDEF     = 8'h08;
  localparam logic [7:0]  LONE_ADDR_LAST      = 8'h0c;
  localparam logic [31:0] LONE_CTRL_RESET     = 32'h00000001;
  localparam int          LONE_CTRL_EN_BIT    = 0;
  typedef enum logic [1:0]
  {
    LONE_SH_LSL = 2'b00,
    LONE_SH_LSR = 2'b01,
    LONE_SH_ASR = 2'b10,
    LONE_SH_ROR = 2'b11
  } lone_shift_t;
endpackage : lone_pkg

// >>> design/lone_exec.sv
// execute stage for no-operation and the three inclusive-or forms
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module lone_exec
  import lone_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_instr_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [63:0] i_op1_data,
  input  wire logic [63:0] i_op2_data,
  output logic             o_instr_ready,
  output logic             o_retire,
  output logic             o_undef,
  output logic [63:0]      o_pc,
  output logic             o_gpr_wr_en,
  output logic [4:0]       o_gpr_wr_index,
  output logic [63:0]      o_gpr_wr_data,
  output logic             o_sp_wr_en,
  output logic [63:0]      o_sp_wr_data,
  output logic             o_move_alias,
  output logic             o_move_inverted_alias,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  import lone_pkg::*;

  // returns {valid, mask}; expands element, rotates, then replicates
  function automatic logic [64:0] bitmask(input logic n,
                                          input logic [5:0] imms,
                                          input logic [5:0] immr);
    logic [6:0]  combo;
    logic [5:0]  levels;
    logic [5:0]  s_v;
    logic [5:0]  r_v;
    logic [63:0] elem;
    logic [63:0] res;
    int          len;
    int          esize;
    logic        ok;
    combo  = {n, ~imms};
    len    = -1;
    elem   = '0;
    res    = '0;
    for (int i = 0; i < 7; i++)
    begin
      if (combo[i])
      begin
        len = i;
      end
    end
    ok = (len >= 1);
    if (len < 1)
    begin
      len = 1;
    end
    esize  = 1 << len;
    levels = 6'(esize - 1);
    s_v    = imms & levels;
    r_v    = immr & levels;
    // all-ones element is a reserved pattern
    if (s_v == levels)
    begin
      ok = 1'b0;
    end
    for (int i = 0; i < 64; i++)
    begin
      elem[i] = (i <= int'(s_v));
    end
    for (int i = 0; i < 64; i++)
    begin
      res[i] = elem[((i % esize) + int'(r_v)) % esize];
    end
    return {ok, res};
  endfunction : bitmask

  // result of the shifter, already cut to the operand width
  function automatic logic [63:0] shift_reg(input logic [63:0] v,
                                            input lone_shift_t ty,
                                            input logic [5:0] amt,
                                            input logic wide);
    logic [127:0] dbl;
    logic [63:0]  r;
    logic [31:0]  w;
    r   = '0;
    dbl = '0;
    w   = v[31:0];
    if (wide)
    begin
      dbl = {v, v};
      case (ty)
        LONE_SH_LSL: r = v << amt;
        LONE_SH_LSR: r = v >> amt;
        LONE_SH_ASR: r = 64'($signed(v) >>> amt);
        LONE_SH_ROR: r = dbl[63:0] >> amt | dbl[127:64] << (7'd64 - amt);
        default:     r = v;
      endcase
    end
    else
    begin
      dbl[63:0] = {w, w};
      case (ty)
        LONE_SH_LSL: r = {32'h0, w << amt[4:0]};
        LONE_SH_LSR: r = {32'h0, w >> amt[4:0]};
        LONE_SH_ASR: r = {32'h0, 32'($signed(w) >>> amt[4:0])};
        LONE_SH_ROR: r = {32'h0, 32'(dbl[63:0] >> amt[4:0])};
        default:     r = {32'h0, w};
      endcase
    end
    return r;
  endfunction : shift_reg

  logic [31:0] ctrl;
  logic [31:0] retired_count;
  logic [31:0] undef_count;
  logic [31:0] last_instr;
  logic        take;
  logic        is_nop;
  logic        is_shreg;
  logic        is_imm;
  logic        wide;
  logic        bad;
  logic [4:0]  rd;
  logic [63:0] op1;
  logic [63:0] op2;
  logic [63:0] sh;
  logic [64:0] bm;
  logic [63:0] next_result;

  assign take = i_instr_valid && o_instr_ready;

  always_comb
  begin
    is_nop   = (i_instr == LONE_NOP_WORD);
    is_shreg = (i_instr[LONE_OPC_HI:LONE_OPC_LO] == LONE_OPC_SHREG);
    is_imm   = (i_instr[LONE_OPC_HI:LONE_IMMOP_LO] == LONE_OPC_IMM);
    wide     = i_instr[LONE_SF_BIT];
    rd       = i_instr[LONE_RD_HI:LONE_RD_LO];
    op1 = (i_instr[LONE_RN_HI:LONE_RN_LO] == LONE_ZERO_REG) ? '0 : i_op1_data;
    op2 = (i_instr[LONE_RM_HI:LONE_RM_LO] == LONE_ZERO_REG) ? '0 : i_op2_data;
    sh = shift_reg(op2, lone_shift_t'(i_instr[LONE_SHTYPE_HI:LONE_SHTYPE_LO]),
                   i_instr[LONE_AMT_HI:LONE_AMT_LO], wide);
    bm = bitmask(wide & i_instr[LONE_N_BIT], i_instr[LONE_AMT_HI:LONE_AMT_LO],
                 i_instr[LONE_IMMR_HI:LONE_IMMR_LO]);
    bad = 1'b0;
    // 32-bit shifted form with amount bit5
    if (is_shreg && !wide && i_instr[LONE_AMT_HI])
    begin
      bad = 1'b1;
    end
    if (is_imm && (!wide && i_instr[LONE_N_BIT] || !bm[64]))
    begin
      bad = 1'b1;
    end
    if (!is_nop && !is_shreg && !is_imm)
    begin
      bad = 1'b1;
    end
    if (is_imm)
    begin
      next_result = op1 | bm[63:0];
    end
    else if (i_instr[LONE_INV_BIT])
    begin
      next_result = op1 | ~sh;
    end
    else
    begin
      next_result = op1 | sh;
    end
    // upper half cleared in 32-bit form
    if (!wide)
    begin
      next_result[63:32] = '0;
    end
  end

  // every accepted instruction answers one cycle later, whatever its data
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_retire <= 1'b0;
      o_undef  <= 1'b0;
      o_pc     <= LONE_PC_RESET;
    end
    else
    begin
      o_retire <= take && !bad;
      o_undef  <= take && bad;
      // pc advances by four on retire
      if (take && !bad)
      begin
        o_pc <= o_pc + LONE_PC_STEP;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_gpr_wr_en           <= 1'b0;
      o_gpr_wr_index        <= '0;
      o_gpr_wr_data         <= '0;
      o_sp_wr_en            <= 1'b0;
      o_sp_wr_data          <= '0;
      o_move_alias          <= 1'b0;
      o_move_inverted_alias <= 1'b0;
    end
    else
    begin
      // no-operation issues no write at all
      o_gpr_wr_en <= take && !bad && !is_nop &&
                     (is_imm ? rd != LONE_ZERO_REG : rd != LONE_ZERO_REG);
      // immediate form to index 31 targets stack pointer
      o_sp_wr_en  <= take && !bad && is_imm && rd == LONE_ZERO_REG;
      if (take)
      begin
        o_gpr_wr_index <= rd;
        o_gpr_wr_data  <= next_result;
        o_sp_wr_data   <= next_result;
      end
      o_move_alias <= take && !bad && is_shreg && !i_instr[LONE_INV_BIT] &&
                      i_instr[LONE_SHTYPE_HI:LONE_SHTYPE_LO] == LONE_SH_LSL &&
                      i_instr[LONE_AMT_HI:LONE_AMT_LO] == LONE_AMT_ZERO &&
                      i_instr[LONE_RN_HI:LONE_RN_LO] == LONE_ZERO_REG;
      o_move_inverted_alias <= take && !bad && is_shreg &&
                      i_instr[LONE_INV_BIT] &&
                      i_instr[LONE_RN_HI:LONE_RN_LO] == LONE_ZERO_REG;
    end
  end

  // acceptance looks only at the enable, never at data
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_instr_ready <= 1'b0;
    end
    else
    begin
      o_instr_ready <= ctrl[LONE_CTRL_EN_BIT];
    end
  end

  // counters saturate rather than wrap so software sees an honest ceiling
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      retired_count <= '0;
      undef_count   <= '0;
      last_instr    <= '0;
    end
    else if (take)
    begin
      last_instr <= i_instr;
      if (!bad && retired_count != 32'hffffffff)
      begin
        retired_count <= retired_count + 32'h1;
      end
      if (bad && undef_count != 32'hffffffff)
      begin
        undef_count <= undef_count + 32'h1;
      end
    end
  end

  // apb slave: one wait state so that pready leaves a flip-flop
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
      ctrl    <= LONE_CTRL_RESET;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        prdata  <= '0;
        pslverr <= 1'b0;
        case (paddr)
          LONE_ADDR_CTRL:    prdata <= pwrite ? '0 : ctrl;
          LONE_ADDR_RETIRED: prdata <= pwrite ? '0 : retired_count;
          LONE_ADDR_UNDEF:   prdata <= pwrite ? '0 : undef_count;
          LONE_ADDR_LAST:    prdata <= pwrite ? '0 : last_instr;
          default:           pslverr <= 1'b1;
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == LONE_ADDR_CTRL)
      begin
        ctrl <= {31'h0, pwdata[LONE_CTRL_EN_BIT]};
      end
    end
  end
endmodule : lone_exec

// >>> verif/lone_exec_assertions.sv
// port checks for the execute block
`timescale 1ns/1ps
module lone_exec_assertions
  import lone_pkg::*;
(
  input logic        i_sys_clk,
  input logic        i_reset_n,
  input logic        i_instr_valid,
  input logic [31:0] i_instr,
  input logic [63:0] i_op1_data,
  input logic [63:0] i_op2_data,
  input logic        o_instr_ready,
  input logic        o_retire,
  input logic        o_undef,
  input logic [63:0] o_pc,
  input logic        o_gpr_wr_en,
  input logic [63:0] o_gpr_wr_data,
  input logic        o_sp_wr_en
);
  logic tk;
  assign tk = i_instr_valid && o_instr_ready;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  chk_one_answer: assert property (tk |=> o_retire != o_undef)
    else $error("taken word lacks one answer");
  chk_nop_quiet: assert property (tk && i_instr == LONE_NOP_WORD
    |=> o_retire && !o_gpr_wr_en && !o_sp_wr_en)
    else $error("no-operation changed state");
  chk_pc_step: assert property (o_retire
    |-> o_pc == $past(o_pc) + LONE_PC_STEP)
    else $error("pc did not step by four");
  chk_undef_hold: assert property (o_undef
    |-> $stable(o_pc) && !o_gpr_wr_en && !o_sp_wr_en)
    else $error("undefined word changed state");
  chk_orn_value: assert property (tk && i_instr[31:21] == 11'h551
    && i_instr[15:10] == LONE_AMT_ZERO && i_instr[9:5] != LONE_ZERO_REG
    && i_instr[20:16] != LONE_ZERO_REG && i_instr[4:0] != LONE_ZERO_REG
    |=> o_gpr_wr_data == ($past(i_op1_data) | ~$past(i_op2_data)))
    else $error("or-not result wrong");
  chk_upper_zero: assert property (o_gpr_wr_en
    && !$past(i_instr[31]) |-> o_gpr_wr_data[63:32] == 32'h0)
    else $error("narrow result upper half set");
  chk_amt5_undef: assert property (tk && !i_instr[31]
    && i_instr[30:24] == LONE_OPC_SHREG && i_instr[15] |=> o_undef)
    else $error("narrow shift amount not refused");
  chk_imm_n_undef: assert property (tk
    && i_instr[31:22] == {1'b0, LONE_OPC_IMM, 1'b1} |=> o_undef)
    else $error("narrow immediate with n set not refused");
endmodule : lone_exec_assertions
bind lone_exec lone_exec_assertions lone_exec_assertions_i (.*);

// >>> verif/lone_regfile.sv
// register file model feeding operands to the execute block
`timescale 1ns/1ps
module lone_regfile (
  input  logic        i_clk,
  input  logic        i_reset_n,
  input  logic [31:0] i_instr,
  input  logic        i_wr_en,
  input  logic [4:0]  i_wr_index,
  input  logic [63:0] i_wr_data,
  output logic [63:0] o_op1,
  output logic [63:0] o_op2
);
  logic [63:0] x [0:31];
  // slot 31 moves every cycle so a missed zeroing cannot hide
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      for (int i = 0; i < 32; i++)
        x[i] <= 64'h9e3779b97f4a7c15 * 64'(i + 1);
    else
    begin
      x[31] <= ~x[31];
      if (i_wr_en)
        x[i_wr_index] <= i_wr_data;
    end
  end
  assign o_op1 = x[i_instr[9:5]];
  assign o_op2 = x[i_instr[20:16]];
endmodule : lone_regfile

// >>> verif/logical_or_nop_execute_tb.sv
// self-checking bench for the execute block
`timescale 1ns/1ps
module logical_or_nop_execute_tb;
  import lone_pkg::*;
  logic        i_sys_clk, i_reset_n, i_instr_valid, psel, penable, pwrite;
  logic        o_instr_ready, o_retire, o_undef, o_gpr_wr_en, o_sp_wr_en;
  logic        o_move_alias, o_move_inverted_alias, pready, pslverr, e;
  logic [31:0] i_instr, pwdata, prdata, q, w, k, r, lastw;
  logic [63:0] i_op1_data, i_op2_data, o_pc, o_gpr_wr_data, o_sp_wr_data;
  logic [63:0] pc_exp;
  logic [7:0]  paddr;
  logic [4:0]  o_gpr_wr_index;
  logic [31:0] corner [8];
  int          n_fail = 0, checked = 0, seed = 4, cyc = 0, n_ret = 0;
  int          n_und = 0;
  lone_exec lone_exec_i (.*);
  lone_regfile lone_regfile_i (.i_clk(i_sys_clk), .i_reset_n, .i_instr,
    .i_wr_en(o_gpr_wr_en), .i_wr_index(o_gpr_wr_index),
    .i_wr_data(o_gpr_wr_data), .o_op1(i_op1_data), .o_op2(i_op2_data));
  task chk_bit(input logic g, input logic x, input string m);
    checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk_bit
  task chk_word(input logic [63:0] g, input logic [63:0] x, input string m);
    checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("FAIL %0t %s %h %h", $time, m, g, x);
    end
  endtask : chk_word
  task tally_and_finish;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // the slave may add wait states, so only the timeout bounds this
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do @(posedge i_sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  function automatic logic [63:0] sh(input logic [1:0] t, input logic [5:0] a,
    input logic wd, input logic [63:0] v);
    logic [63:0] u, m;
    m = wd ? '1 : 64'h00000000ffffffff;
    u = v & m;
    case (t)
      LONE_SH_LSL: u = u << a;
      LONE_SH_LSR: u = u >> a;
      LONE_SH_ASR: u = $signed(wd ? v : {{32{v[31]}}, v[31:0]}) >>> a;
      default: u = (u >> a) | (u << ((wd ? 7'd64 : 7'd32) - {1'b0, a}));
    endcase
    return u & m;
  endfunction : sh
  // bitmask operand built from the rule: ones, rotate, replicate; bit 64 valid
  function automatic logic [64:0] bmask(input logic n, input logic [5:0] s,
    input logic [5:0] r);
    logic [63:0] e;
    logic [5:0]  lv;
    int          len, sz;
    len = n ? 6 : -1;
    for (int i = 0; i < 6; i++)
      if (!n && !s[i])
        len = i;
    if (len < 1)
      return '0;
    sz = 1 << len;
    lv = 6'(sz - 1);
    if ((s & lv) == lv)
      return '0;
    e = (64'h1 << ({1'b0, s & lv} + 7'd1)) - 64'h1;
    e = (e >> (r & lv)) | (e << (sz - int'(r & lv)));
    if (sz < 64)
      e = e & ((64'h1 << sz) - 64'h1);
    for (int j = sz; j < 64; j = j * 2)
      e = e | (e << j);
    return {1'b1, e};
  endfunction : bmask
  task run_one(input logic [31:0] w);
    logic [63:0] a, b, x, m;
    logic sf, sr, im, un, nop, r31;
    logic [64:0] bk;
    sf = w[31];
    m = sf ? '1 : 64'h00000000ffffffff;
    nop = w == LONE_NOP_WORD;
    sr = w[30:24] == LONE_OPC_SHREG;
    im = w[30:23] == LONE_OPC_IMM;
    bk = bmask(w[22], w[15:10], w[21:16]);
    un = !(sr || im || nop) || (!sf && (sr ? w[15] : im && w[22]))
      || (im && !bk[64]);
    r31 = w[4:0] == LONE_ZERO_REG;
    @(posedge i_sys_clk);
    i_instr <= w;
    i_instr_valid <= 1'b1;
    #1;
    a = (w[9:5] == LONE_ZERO_REG) ? '0 : i_op1_data;
    b = (w[20:16] == LONE_ZERO_REG) ? '0 : i_op2_data;
    x = sh(w[23:22], w[15:10], sf, b) ^ {64{w[21]}};
    if (im)
      x = bk[63:0];
    x = (a | x) & m;
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b0;
    #1;
    pc_exp = pc_exp + (un ? 64'h0 : LONE_PC_STEP);
    n_ret += int'(!un);
    n_und += int'(un);
    lastw = w;
    chk_bit(o_undef, un, "undef");
    chk_bit(o_retire, !un, "retire");
    chk_word(o_pc, pc_exp, "pc");
    chk_bit(o_sp_wr_en, !un && im && r31, "sp en");
    chk_bit(o_gpr_wr_en, !un && !nop && !r31, "gpr en");
    if (o_sp_wr_en === 1'b1)
      chk_word(o_sp_wr_data, x, "sp data");
    if (o_gpr_wr_en === 1'b1)
      chk_word(o_gpr_wr_data, x, "result");
    if (o_gpr_wr_en === 1'b1)
      chk_word({59'h0, o_gpr_wr_index}, {59'h0, w[4:0]}, "index");
    chk_bit(o_move_alias, !un && sr && !w[21] && w[23:22] == 2'b00
      && w[15:10] == LONE_AMT_ZERO && w[9:5] == LONE_ZERO_REG, "mov");
    chk_bit(o_move_inverted_alias, !un && sr && w[21]
      && w[9:5] == LONE_ZERO_REG, "mvn");
  endtask : run_one
  initial
  begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial
  begin
    {i_reset_n, i_instr_valid, psel, penable, pwrite, paddr} = '0;
    {i_instr, pwdata, pc_exp} = '0;
    corner = '{{1'b1, 7'h2a, 2'b00, 1'b0, 5'd3, 6'd0, 5'd31, 5'd7},
      {1'b0, 7'h2a, 2'b11, 1'b1, 5'd31, 6'd31, 5'd31, 5'd2},
      {1'b0, 8'h64, 1'b0, 6'd31, 6'd0, 5'd4, 5'd31},
      {1'b1, 7'h2a, 2'b10, 1'b0, 5'd5, 6'd63, 5'd6, 5'd8},
      {1'b0, 8'h64, 1'b1, 6'd0, 6'd0, 5'd1, 5'd1},
      {1'b1, 7'h2a, 2'b00, 1'b1, 5'd9, 6'd0, 5'd10, 5'd11},
      {1'b1, 8'h64, 1'b1, 6'd0, 6'h3f, 5'd1, 5'd2}, 32'h00000000};
    repeat (8) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    apb(1'b0, LONE_ADDR_CTRL, 32'h0);
    chk_word({32'h0, q}, {32'h0, LONE_CTRL_RESET}, "ctrl");
    apb(1'b1, 8'h10, 32'hffffffff);
    chk_bit(e, 1'b1, "unmapped");
    apb(1'b1, LONE_ADDR_CTRL, 32'h0);
    @(posedge i_sys_clk);
    {i_instr, i_instr_valid} <= {LONE_NOP_WORD, 1'b1};
    repeat (3)
    begin
      @(posedge i_sys_clk);
      #1;
      chk_bit(o_retire, 1'b0, "refused");
      chk_bit(o_instr_ready, 1'b0, "ready low");
    end
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b0;
    apb(1'b1, LONE_ADDR_CTRL, 32'h1);
    $display("test registers done");
    foreach (corner[i])
      run_one(corner[i]);
    repeat (300)
    begin
      k = $random(seed);
      r = $random(seed);
      case (k[1:0])
        2'd0: w = LONE_NOP_WORD;
        2'd1: w = {r[31], LONE_OPC_IMM, r[22:0]};
        default: w = {r[31], LONE_OPC_SHREG, r[23:22], k[2], r[20:0]};
      endcase
      run_one(w);
    end
    $display("test instructions done");
    apb(1'b0, LONE_ADDR_RETIRED, 32'h0);
    chk_word({32'h0, q}, 64'(n_ret), "retired");
    apb(1'b0, LONE_ADDR_UNDEF, 32'h0);
    chk_word({32'h0, q}, 64'(n_und), "undefined");
    apb(1'b0, LONE_ADDR_LAST, 32'h0);
    chk_word({32'h0, q}, {32'h0, lastw}, "last");
    $display("test counters done");
    tally_and_finish();
  end
endmodule : logical_or_nop_execute_tb
